// File: hw/fcds_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Each channel repeats a dimming cycle near 5 ms, on for a programmed time.
// - An on entry raises the channel run event; an off entry drops it.
// - Channel starts are a quarter period apart so turn-ons never coincide.
// - Start instants are fixed by the table; only on-time lengths differ.
// - On-time counts 20 us units built from a 1 us tick.
// - Schedule has 8 entries: channel, on/off action, delay up to 511 units.
// - After each event the tick timer reloads with the delay of the entry just executed.
// - Switching a channel on arms its delayed voltage acquisition.
// - Four interleaved samples each of supply and common node, averaged, stored.
// - Samples are discarded when the channel is no longer active.
// - A done flag is raised when an acquisition stores fresh voltages; the startup store leaves it low.
// - Overcurrent state only from fault zone; its exit raises an event.
// - Overcurrent exit clears the run event unless an on entry fires that cycle, sets a fault; next cycle restarts.
// - New engine parameters stay pending until the engine is in its off-time or hold state.
// - Schedule changes go to a shadow, copied at the next period start.
// - Serial traffic ranks below all sources here; none of it enters this block.
// - Overcurrent is detected by the engine alone within a few clocks.
// - On overcurrent the PWM output goes low and an event is raised.
// - An error code is latched while monitoring continues.
// - At startup, analog input 0 is converted and stored for all channels.
// - Button reads on analog input 7 never collide with acquisitions.
// - Overcurrent holds PWM low for the maximum hold time, then off-time.
// - Run event is a level; off-time state sees it low and goes to hold.
module fcds_top
	import fcds_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [NCH-1:0]   current_compare_input,
	output logic      [NCH-1:0]   pwm,
	output logic      [NCH-1:0]   run_event,
	output logic                  adc_start,
	output logic      [2:0]       adc_chan,
	input  wire logic             adc_done,
	input  wire logic [ADC_W-1:0] adc_data
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
		input logic [7:0] span);
		hit = (a >= base) && ((a - base) < span) && (a[1:0] == 2'h0);
	endfunction : hit

	logic                  wr;
	logic                  ctrl_en_q;
	logic                  upd_pend_q;
	logic                  btn_pend_q;
	logic                  init_q;
	logic                  done_q;
	logic [2:0]            err_q;
	logic [ADC_W-1:0]      btn_q;
	logic [31:0]           rdata_q;
	logic                  rerr_q;
	logic [7:0]            us_q;
	logic [4:0]            unit_q;
	logic                  us_tick;
	logic                  unit_tick;
	fcds_sched_t           act_q [NENT];
	fcds_sched_t           shd_q [NENT];
	fcds_sched_t           ent;
	logic [2:0]            idx_q;
	logic [DLY_W-1:0]      dcnt_q;
	logic                  fire;
	logic                  copy_now;
	logic [NCH-1:0]        ev_on;
	logic [NCH-1:0]        ev_off;
	logic [NCH-1:0]        cmp_s1_q;
	logic [NCH-1:0]        cmp_s2_q;
	logic [NCH-1:0]        ovc_exit;
	logic [NCH-1:0]        active;
	logic [NCH-1:0]        flt_q;
	logic [NCH-1:0]        acq_req_q;
	logic [NCH-1:0]        par_wr;
	fcds_eng_t             st_q [NCH];
	fcds_eng_t             st_d [NCH];
	logic [TMR_W-1:0]      tmr_q [NCH];
	fcds_param_t           par_q [NCH];
	fcds_param_t           pendv_q [NCH];
	logic [NCH-1:0]        pend_q;
	logic [ADC_W-1:0]      vsup_q [NCH];
	logic [ADC_W-1:0]      vcom_q [NCH];
	fcds_aq_t              aq_q;
	fcds_kind_t            kind_q;
	logic [1:0]            aq_ch_q;
	logic [2:0]            n_q;
	logic [ADC_W+1:0]      sum_sup_q;
	logic [ADC_W+1:0]      sum_com_q;
	logic [ADC_W+1:0]      sum_com_end;
	logic                  grant_acq;
	logic [1:0]            gnt_ch;
	logic                  stored;

	assign wr      = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	assign pslverr = psel & penable & rerr_q;

	// Read data and error are captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			rdata_q <= 32'h0;
			rerr_q  <= 1'b0;
		end
		else if (psel & !penable)
		begin
			rdata_q <= 32'h0;
			rerr_q  <= 1'b0;
			if (paddr == OFF_CTRL)
				rdata_q <= {29'h0, btn_pend_q, upd_pend_q, ctrl_en_q};
			else if (paddr == OFF_STAT)
				rdata_q <= {13'h0, err_q, 2'h0, pwm, init_q, done_q, flt_q, run_event};
			else if (paddr == OFF_BTN)
				rdata_q <= {22'h0, btn_q};
			else if (hit(paddr, OFF_SHD, SPAN_SHD))
				rdata_q <= {20'h0, shd_q[paddr[4:2]]};
			else if (hit(paddr, OFF_PAR, SPAN_CH))
				rdata_q <= {2'h0, pendv_q[paddr[3:2]]};
			else if (hit(paddr, OFF_VOLT, SPAN_CH))
				rdata_q <= {6'h0, vcom_q[paddr[3:2]], 6'h0, vsup_q[paddr[3:2]]};
			else
				rerr_q <= 1'b1;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_en_q  <= 1'b0;
			upd_pend_q <= 1'b0;
			btn_pend_q <= 1'b0;
		end
		else
		begin
			if (wr && paddr == OFF_CTRL)
				ctrl_en_q <= pwdata[CB_EN];
			if (wr && paddr == OFF_CTRL && pwdata[CB_UPD])
				upd_pend_q <= 1'b1;
			else if (copy_now)
				upd_pend_q <= 1'b0;
			if (wr && paddr == OFF_CTRL && pwdata[CB_BTN])
				btn_pend_q <= 1'b1;
			else if (aq_q == AQ_CONV && kind_q == K_BTN && adc_done)
				btn_pend_q <= 1'b0;
		end

	// 1 us tick and 20 us unit tick
	assign us_tick   = (us_q == 8'(TICK_RES_CYC - 1));
	assign unit_tick = us_tick && (unit_q == 5'(UNIT_US - 1));

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			us_q   <= 8'h0;
			unit_q <= 5'h0;
		end
		else
		begin
			us_q <= us_tick ? 8'h0 : us_q + 8'h1;
			if (us_tick)
				unit_q <= (unit_q == 5'(UNIT_US - 1)) ? 5'h0 : unit_q + 5'h1;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			shd_q <= SCHED_RST;
		else if (wr && hit(paddr, OFF_SHD, SPAN_SHD))
			shd_q[paddr[4:2]] <= pwdata[11:0];

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			act_q <= SCHED_RST;
		else if (copy_now)
			act_q <= shd_q;

	// Zero delay entries fire on consecutive cycles within one unit
	assign ent      = act_q[idx_q];
	assign fire     = ctrl_en_q && init_q && (dcnt_q == 9'h0);
	assign copy_now = fire && (idx_q == 3'h0) && upd_pend_q;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			idx_q  <= 3'h0;
			dcnt_q <= 9'h0;
		end
		else if (!ctrl_en_q)
		begin
			idx_q  <= 3'h0;
			dcnt_q <= 9'h0;
		end
		else if (fire && !copy_now)
		begin
			idx_q  <= idx_q + 3'h1;
			dcnt_q <= ent.dly;
		end
		else if (unit_tick && dcnt_q != 9'h0)
			dcnt_q <= dcnt_q - 9'h1;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			cmp_s1_q <= '0;
			cmp_s2_q <= '0;
		end
		else
		begin
			cmp_s1_q <= current_compare_input;
			cmp_s2_q <= cmp_s1_q;
		end

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		logic [6:0] wk_q;
		logic       wk_on_q;

		assign ev_on[c]  = fire && !copy_now && ent.on && ent.ch == 2'(c);
		assign ev_off[c] = fire && !copy_now && !ent.on && ent.ch == 2'(c);
		assign par_wr[c] = wr && hit(paddr, OFF_PAR, SPAN_CH) && paddr[3:2] == 2'(c);
		assign ovc_exit[c] = (st_q[c] == E_OVC) && (st_d[c] == E_OFF);
		assign active[c] = run_event[c] && st_q[c] != E_HOLD && st_q[c] != E_IDLE;

		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
				run_event[c] <= 1'b0;
			else if (!ctrl_en_q)
				run_event[c] <= 1'b0;
			else if (ev_on[c])
				run_event[c] <= 1'b1;
			else if (ev_off[c] || ovc_exit[c])
				run_event[c] <= 1'b0;

		always_comb
		begin
			st_d[c] = st_q[c];
			case (st_q[c])
				E_IDLE:
					if (ctrl_en_q)
						st_d[c] = E_OFF;
				E_OFF:
					if (!run_event[c])
						st_d[c] = E_HOLD;
					else if (tmr_q[c] >= par_q[c].toff)
						st_d[c] = E_FZ;
				E_FZ:
					if (cmp_s2_q[c])
						st_d[c] = E_OVC;
					else if (tmr_q[c] >= par_q[c].t1)
						st_d[c] = E_LIM;
				E_LIM:
					if (cmp_s2_q[c] || tmr_q[c] >= par_q[c].t1 + par_q[c].t2)
						st_d[c] = E_OFF;
				E_OVC:
					if (tmr_q[c] >= TMR_W'(OVC_HOLD_CYC - 1))
						st_d[c] = E_OFF;
				E_HOLD:
					if (run_event[c])
						st_d[c] = E_FZ;
				default:
					st_d[c] = E_IDLE;
			endcase
			if (!ctrl_en_q)
				st_d[c] = E_IDLE;
		end

		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
			begin
				st_q[c]  <= E_IDLE;
				tmr_q[c] <= '0;
				pwm[c]   <= 1'b0;
			end
			else
			begin
				st_q[c] <= st_d[c];
				pwm[c]  <= (st_d[c] == E_FZ) || (st_d[c] == E_LIM);
				if (st_d[c] != st_q[c] && !(st_q[c] == E_FZ && st_d[c] == E_LIM))
					tmr_q[c] <= '0;
				else
					tmr_q[c] <= tmr_q[c] + TMR_W'(1);
			end

		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
			begin
				par_q[c]   <= PARAM_RST;
				pendv_q[c] <= PARAM_RST;
				pend_q[c]  <= 1'b0;
			end
			else
			begin
				if (par_wr[c])
					pendv_q[c] <= pwdata[29:0];
				if (par_wr[c])
					pend_q[c] <= 1'b1;
				else if (pend_q[c] && (st_q[c] == E_HOLD || st_q[c] == E_OFF))
				begin
					par_q[c]  <= pendv_q[c];
					pend_q[c] <= 1'b0;
				end
			end

		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
				flt_q[c] <= 1'b0;
			else if (ovc_exit[c])
				flt_q[c] <= 1'b1;
			else if (wr && paddr == OFF_STAT && pwdata[SB_FLT + c])
				flt_q[c] <= 1'b0;

		always_ff @(posedge pclk or negedge presetn)
			if (!presetn)
			begin
				wk_on_q      <= 1'b0;
				wk_q         <= 7'h0;
				acq_req_q[c] <= 1'b0;
			end
			else
			begin
				if (ev_on[c])
				begin
					wk_on_q <= 1'b1;
					wk_q    <= 7'h0;
				end
				else if (wk_on_q && us_tick)
				begin
					wk_q <= wk_q + 7'h1;
					if (wk_q == 7'(WAKE_US - 1))
						wk_on_q <= 1'b0;
				end
				if (wk_on_q && us_tick && wk_q == 7'(WAKE_US - 1))
					acq_req_q[c] <= 1'b1;
				else if (grant_acq && gnt_ch == 2'(c))
					acq_req_q[c] <= 1'b0;
			end

		sequence s_trip;
			(st_q[c] == E_FZ) && cmp_s2_q[c];
		endsequence
		sequence s_ovc_low;
			(st_q[c] == E_OVC) && !pwm[c];
		endsequence
		AST_TRIP_TO_OVC: assert property (@(posedge pclk) disable iff (!presetn)
			s_trip ##0 ctrl_en_q |=> s_ovc_low)
			else $error("trip in fault zone did not enter overcurrent");
		AST_OVC_ONLY_FROM_FZ: assert property (@(posedge pclk) disable iff (!presetn)
			$rose(st_q[c] == E_OVC) |-> $past(st_q[c]) == E_FZ)
			else $error("overcurrent entered from wrong state");
		AST_OVC_HOLD_TIME: assert property (@(posedge pclk) disable iff (!presetn)
			ovc_exit[c] |-> tmr_q[c] == TMR_W'(OVC_HOLD_CYC - 1) ##1 st_q[c] == E_OFF)
			else $error("overcurrent hold time wrong");
		AST_OVC_STOPS_RUN: assert property (@(posedge pclk) disable iff (!presetn)
			ovc_exit[c] && !ev_on[c] |=> !run_event[c] && flt_q[c])
			else $error("overcurrent exit did not stop channel");
		AST_STOP_TO_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
			st_q[c] == E_OFF && !run_event[c] && ctrl_en_q |=> st_q[c] == E_HOLD && !pwm[c])
			else $error("stopped channel did not hold");
		AST_LOAD_WHEN_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
			$fell(pend_q[c]) |-> $past(st_q[c]) == E_HOLD || $past(st_q[c]) == E_OFF)
			else $error("parameters loaded while driving");
		AST_ON_ARMS_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
			ev_on[c] |=> run_event[c] && wk_on_q && wk_q == 7'h0)
			else $error("channel start did not arm acquisition");
	end

	// Startup first, then acquisitions, then button reads share the converter
	always_comb
	begin
		gnt_ch = 2'h0;
		for (int i = NCH - 1; i >= 0; i--)
			if (acq_req_q[i])
				gnt_ch = 2'(i);
	end
	assign grant_acq   = aq_q == AQ_IDLE && init_q && |acq_req_q;
	assign sum_com_end = sum_com_q + (ADC_W + 2)'(adc_data);
	assign stored      = aq_q == AQ_CONV && kind_q == K_ACQ && adc_done && n_q == 3'h7
		&& active[aq_ch_q];

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			aq_q      <= AQ_IDLE;
			kind_q    <= K_INIT;
			aq_ch_q   <= 2'h0;
			n_q       <= 3'h0;
			sum_sup_q <= '0;
			sum_com_q <= '0;
			adc_start <= 1'b0;
			adc_chan  <= AIN_SUP;
			init_q    <= 1'b0;
			btn_q     <= '0;
			vsup_q    <= '{default: '0};
			vcom_q    <= '{default: '0};
		end
		else
		begin
			adc_start <= 1'b0;
			case (aq_q)
				AQ_IDLE:
					if (!init_q)
					begin
						kind_q    <= K_INIT;
						adc_chan  <= AIN_SUP;
						adc_start <= 1'b1;
						aq_q      <= AQ_CONV;
					end
					else if (grant_acq)
					begin
						kind_q    <= K_ACQ;
						aq_ch_q   <= gnt_ch;
						n_q       <= 3'h0;
						sum_sup_q <= '0;
						sum_com_q <= '0;
						adc_chan  <= AIN_SUP;
						adc_start <= 1'b1;
						aq_q      <= AQ_CONV;
					end
					else if (btn_pend_q)
					begin
						kind_q    <= K_BTN;
						adc_chan  <= AIN_BTN;
						adc_start <= 1'b1;
						aq_q      <= AQ_CONV;
					end
				AQ_CONV:
					if (adc_done)
						case (kind_q)
							K_INIT:
							begin
								vsup_q <= '{default: adc_data};
								init_q <= 1'b1;
								aq_q   <= AQ_IDLE;
							end
							K_BTN:
							begin
								btn_q <= adc_data;
								aq_q  <= AQ_IDLE;
							end
							default:
								if (n_q == 3'h7)
								begin
									if (active[aq_ch_q])
									begin
										vsup_q[aq_ch_q] <= sum_sup_q[ADC_W+1:2];
										vcom_q[aq_ch_q] <= sum_com_end[ADC_W+1:2];
									end
									aq_q <= AQ_IDLE;
								end
								else
								begin
									if (n_q[0])
										sum_com_q <= sum_com_end;
									else
										sum_sup_q <= sum_sup_q + (ADC_W + 2)'(adc_data);
									n_q       <= n_q + 3'h1;
									adc_chan  <= n_q[0] ? AIN_SUP : AIN_COM0 + 3'(aq_ch_q);
									adc_start <= 1'b1;
								end
						endcase
				default:
					aq_q <= AQ_IDLE;
			endcase
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			done_q <= 1'b0;
		else if (stored)
			done_q <= 1'b1;
		else if (wr && paddr == OFF_STAT && pwdata[SB_DONE])
			done_q <= 1'b0;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			err_q <= 3'h0;
		else
			for (int i = 0; i < NCH; i++)
				if (ovc_exit[i])
					err_q <= {1'b1, 2'(i)};

	AST_DONE_ON_STORE: assert property (@(posedge pclk) disable iff (!presetn)
		stored |=> done_q)
		else $error("done flag not raised");
	AST_DISCARD: assert property (@(posedge pclk) disable iff (!presetn)
		aq_q == AQ_CONV && kind_q == K_ACQ && adc_done && n_q == 3'h7 && !active[aq_ch_q]
		|=> !$rose(done_q) && $stable(vsup_q[aq_ch_q]) && $stable(vcom_q[aq_ch_q]))
		else $error("inactive channel samples were stored");
	AST_COPY_SHADOW: assert property (@(posedge pclk) disable iff (!presetn)
		copy_now |=> act_q[0] == $past(shd_q[0]) && !upd_pend_q && idx_q == 3'h0)
		else $error("shadow not copied at period start");
	AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
		fire && !copy_now |=> dcnt_q == $past(ent.dly) && idx_q == $past(idx_q) + 3'h1)
		else $error("tick timer not reloaded from schedule");
	AST_BTN_AFTER_ACQ: assert property (@(posedge pclk) disable iff (!presetn)
		aq_q == AQ_IDLE && init_q && |acq_req_q |=> kind_q == K_ACQ && adc_chan == AIN_SUP)
		else $error("button read took converter ahead of acquisition");
endmodule : fcds_top

// File: hw/fcds_pkg.sv
package fcds_pkg;
	localparam int NCH          = 4;
	localparam int NENT         = 8;
	localparam int ADC_W        = 10;
	localparam int TMR_W        = 10;
	localparam int DLY_W        = 9;
	localparam int CLK_MHZ      = 200;
	localparam int TICK_RES_US  = 1;
	localparam int TICK_RES_CYC = TICK_RES_US * CLK_MHZ;
	localparam int UNIT_US      = 20;
	localparam int WAKE_US      = 100;
	localparam int OVC_HOLD_NS  = 5000;
	localparam int OVC_HOLD_CYC = OVC_HOLD_NS * CLK_MHZ / 1000;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_BTN  = 8'h08;
	localparam logic [7:0] OFF_SHD  = 8'h20;
	localparam logic [7:0] OFF_PAR  = 8'h40;
	localparam logic [7:0] OFF_VOLT = 8'h60;
	localparam logic [7:0] SPAN_SHD = 8'h20;
	localparam logic [7:0] SPAN_CH  = 8'h10;

	localparam int CB_EN    = 0;
	localparam int CB_UPD   = 1;
	localparam int CB_BTN   = 2;
	localparam int SB_RUN   = 0;
	localparam int SB_FLT   = 4;
	localparam int SB_DONE  = 8;
	localparam int SB_INIT  = 9;
	localparam int SB_PWM   = 10;
	localparam int SB_ERR   = 16;
	localparam int PB_T1    = 10;
	localparam int PB_T2    = 20;
	localparam int VB_COM   = 16;

	localparam logic [2:0] AIN_SUP  = 3'h0;
	localparam logic [2:0] AIN_COM0 = 3'h1;
	localparam logic [2:0] AIN_BTN  = 3'h7;

	typedef struct packed {
		logic [1:0]       ch;
		logic             on;
		logic [DLY_W-1:0] dly;
	} fcds_sched_t;

	typedef struct packed {
		logic [TMR_W-1:0] t2;
		logic [TMR_W-1:0] t1;
		logic [TMR_W-1:0] toff;
	} fcds_param_t;

	typedef enum logic [5:0] {
		E_IDLE = 6'h01,
		E_OFF  = 6'h02,
		E_FZ   = 6'h04,
		E_LIM  = 6'h08,
		E_OVC  = 6'h10,
		E_HOLD = 6'h20
	} fcds_eng_t;

	typedef enum logic [1:0] {
		AQ_IDLE = 2'h1,
		AQ_CONV = 2'h2
	} fcds_aq_t;

	typedef enum logic [2:0] {
		K_INIT = 3'h1,
		K_ACQ  = 3'h2,
		K_BTN  = 3'h4
	} fcds_kind_t;

	localparam fcds_param_t PARAM_RST = '{t2: 10'h0C0, t1: 10'h060, toff: 10'h0C8};
	localparam fcds_sched_t SCHED_RST [NENT] = '{
		'{2'h2, 1'h0, 9'h000}, '{2'h0, 1'h1, 9'h040},
		'{2'h3, 1'h0, 9'h000}, '{2'h1, 1'h1, 9'h040},
		'{2'h0, 1'h0, 9'h000}, '{2'h2, 1'h1, 9'h040},
		'{2'h1, 1'h0, 9'h000}, '{2'h3, 1'h1, 9'h040}};
endpackage : fcds_pkg

// File: bench/fcds_partner.sv
`timescale 1ns/100ps
module fcds_partner
	import fcds_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [NCH-1:0]   pwm,
	input  wire logic [NCH-1:0]   fault,
	input  wire logic [ADC_W-1:0] adc_value,
	input  wire logic             adc_start,
	output logic      [NCH-1:0]   current_compare_input,
	output logic                  adc_done,
	output logic      [ADC_W-1:0] adc_data
);
	logic [7:0] ramp_q [NCH];
	logic [2:0] wait_q;

	// Current ramps while the gate is on; a shorted string trips at once
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ramp_q <= '{default: 8'h00};
		else
			for (int c = 0; c < NCH; c++)
				ramp_q[c] <= !pwm[c] ? 8'h00 : ramp_q[c] + {7'h00, ramp_q[c] != 8'hFF};

	always_comb
		for (int c = 0; c < NCH; c++)
			current_compare_input[c] = pwm[c] & (fault[c] | (ramp_q[c] >= 8'h96));

	// Converter with 1 to 4 cycles of latency; the data bus changes every cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			wait_q   <= 3'h0;
			adc_done <= 1'b0;
			adc_data <= '0;
		end
		else
		begin
			adc_data <= adc_value;
			adc_done <= wait_q == 3'h1;
			if (adc_start)
				wait_q <= {1'b0, adc_value[1:0]} + 3'h1;
			else if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
		end
endmodule : fcds_partner

// File: bench/fcds_top_test.sv
`timescale 1ns/100ps
module fcds_top_test
	import fcds_pkg::*;
;
	localparam int          UNIT_CYC = UNIT_US * CLK_MHZ;
	localparam fcds_param_t NEW_PAR  = '{t2: 10'h0C0, t1: 10'h050, toff: 10'h100};
	logic             pclk;
	logic             presetn;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [NCH-1:0]   cmp;
	logic [NCH-1:0]   pwm;
	logic [NCH-1:0]   run_event;
	logic [NCH-1:0]   fault;
	logic [NCH-1:0]   prev = '0;
	logic [NCH-1:0]   acq_done = '0;
	logic             adc_start;
	logic             adc_done;
	logic [2:0]       adc_chan;
	logic [ADC_W-1:0] adc_data;
	logic [ADC_W-1:0] adc_value;
	logic [ADC_W-1:0] btn_val;
	logic [ADC_W-1:0] exp_sup [NCH];
	logic [ADC_W-1:0] exp_com [NCH];
	logic [31:0]      rng;
	logic [31:0]      r;
	logic             e;
	logic [2:0]       exp_q [$];
	int               acq_q [$];
	int               n_mismatch = 0;
	int               total_checks = 0;
	int               n_conv = 0;
	int               k = 0;
	int               ss = 0;
	int               sc = 0;
	int               cyc = 0;
	int               t_on = 0;
	fcds_sched_t      tbl [NENT] = '{'{2'h0, 1'h1, 9'h006}, '{2'h0, 1'h0, 9'h000},
		'{2'h1, 1'h1, 9'h002}, '{2'h1, 1'h0, 9'h001}, '{2'h2, 1'h1, 9'h001},
		'{2'h2, 1'h0, 9'h001}, '{2'h3, 1'h1, 9'h001}, '{2'h3, 1'h0, 9'h001}};

	fcds_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .current_compare_input(cmp), .pwm(pwm), .run_event(run_event),
		.adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));

	fcds_partner u_partner (.pclk(pclk), .presetn(presetn), .pwm(pwm), .fault(fault),
		.adc_value(adc_value), .adc_start(adc_start), .current_compare_input(cmp),
		.adc_done(adc_done), .adc_data(adc_data));

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs

	task automatic give_verdict;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic poll(input logic [7:0] a, input int b, input logic v);
		do
			apb(1'b0, a, 32'h0);
		while (r[b] !== v);
	endtask : poll

	initial
	begin
		pclk = 1'b0;
		forever
			#2.5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cyc++;
		rng <= xs(rng);
		adc_value <= rng[ADC_W-1:0];
	end

	// Reference model of the schedule order and of each acquisition
	always @(posedge pclk)
		if (presetn)
		begin
			logic [2:0] ec;
			int         ac;
			int         dt;
			for (int c = 0; c < NCH; c++)
				if (run_event[c] !== prev[c])
				begin
					check("run_event", 32'({c[1:0], run_event[c]}), 32'(exp_q.pop_front()));
					if (run_event[c])
						acq_q.push_back(c);
					if (c == 0 && run_event[c])
						t_on = cyc;
					else if (c == 0)
					begin
						dt = cyc - t_on;
						check("on_time", 32'(dt > 5 * UNIT_CYC && dt <= 6 * UNIT_CYC + 50), 1);
					end
				end
			if (n_conv == 0 || acq_q.size() == 0)
				ec = n_conv == 0 ? AIN_SUP : AIN_BTN;
			else
				ec = k % 2 == 1 ? 3'(acq_q[0] + 1) : AIN_SUP;
			if (adc_start)
				check("adc_chan", 32'(adc_chan), 32'(ec));
			if (adc_done)
			begin
				if (n_conv == 0)
					exp_sup = '{default: adc_data};
				else if (acq_q.size() == 0)
					btn_val = adc_data;
				else
				begin
					if (k % 2 == 1)
						sc += adc_data;
					else
						ss += adc_data;
					k++;
					if (k == 8)
					begin
						ac = acq_q.pop_front();
						if (run_event[ac])
						begin
							exp_sup[ac] = ADC_W'(ss >> 2);
							exp_com[ac] = ADC_W'(sc >> 2);
						end
						acq_done[ac] = 1'b1;
						k = 0;
						ss = 0;
						sc = 0;
					end
				end
				n_conv++;
			end
			prev = run_event;
		end

	initial
	begin
		#450000;
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, fault} = '0;
		rng = 32'hACAFD42A;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		poll(OFF_STAT, SB_INIT, 1'b1);
		for (int c = 0; c < NCH; c++)
		begin
			apb(1'b0, 8'(OFF_VOLT + 4 * c), 32'h0);
			check("volt_startup", 32'(r[ADC_W-1:0]), 32'(exp_sup[c]));
		end
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped", 32'({e, r != 32'h0}), 32'h2);
		apb(1'b1, 8'(OFF_PAR + 8), 32'(NEW_PAR));
		apb(1'b0, 8'(OFF_PAR + 8), 32'h0);
		check("param", r, 32'(NEW_PAR));
		apb(1'b1, OFF_CTRL, 32'h4);
		poll(OFF_CTRL, CB_BTN, 1'b0);
		apb(1'b0, OFF_BTN, 32'h0);
		check("button", 32'(r[ADC_W-1:0]), 32'(btn_val));
		for (int i = 0; i < NENT; i++)
		begin
			apb(1'b1, 8'(OFF_SHD + 4 * i), 32'(tbl[i]));
			exp_q.push_back({tbl[i].ch, tbl[i].on});
		end
		// The second period repeats the same order of events
		for (int i = 0; i < NENT; i++)
			exp_q.push_back(exp_q[i]);
		// The shadow copy needs a running schedule, so enable goes with the request
		apb(1'b1, OFF_CTRL, 32'h3);
		poll(OFF_CTRL, CB_UPD, 1'b0);
		apb(1'b1, OFF_STAT, 32'h100);
		fault <= 4'h2;
		apb(1'b1, OFF_CTRL, 32'h1);
		poll(OFF_STAT, SB_DONE, 1'b1);
		apb(1'b0, OFF_VOLT, 32'h0);
		check("volt_ch0", r, {6'h00, exp_com[0], 6'h00, exp_sup[0]});
		apb(1'b1, OFF_STAT, 32'h100);
		poll(OFF_STAT, SB_FLT + 1, 1'b1);
		check("error_code", 32'(r[18:16]), 32'h5);
		check("ovc_outputs", 32'({r[SB_PWM+1], r[SB_RUN+1], r[SB_PWM], run_event[1]}), 0);
		wait (acq_done[1] === 1'b1);
		repeat (20) @(posedge pclk);
		apb(1'b0, OFF_STAT, 32'h0);
		check("done_discard", 32'(r[SB_DONE]), 0);
		apb(1'b0, 8'(OFF_VOLT + 4), 32'h0);
		check("volt_ch1", 32'(r[ADC_W-1:0]), 32'(exp_sup[1]));
		// The tripped channel restarts at its next scheduled period
		wait (run_event[1] === 1'b1);
		repeat (2) @(posedge pclk);
		give_verdict();
	end
endmodule : fcds_top_test
